// *** core/rprr_top.sv ***
// Ranging and phase measurement result register bank
// Functional notes
// RULE_01: Late correlator magnitude tap is an 8-bit read-only field, reset zero.
// RULE_02: Frequency offset first estimate is loaded when the frame header is found.
// RULE_03: At frame end the averaged frame-wide offset replaces the estimate.
// RULE_04: Frequency offset is two's complement, minus to plus ninety degrees.
// RULE_05: 24-bit flight time spans low, middle, high byte registers.
// RULE_06: Flight time counts cycles of a 16 MHz timer.
// RULE_07: Ranging results are mapped only while ranging enable is one.
// RULE_08: Phase is measured against internal reference in the low-IF domain.
// RULE_09: Phase value is captured into its register every 8 microseconds.
// RULE_10: Control bit 5 enables the phase unit; phase register valid only then.
// RULE_11: Control bit 4 selects normal or inverse IF position for phase path.
// RULE_12: Control holds clock output fields low, ranging enable bit 7, bit 6 RO.
// RULE_13: Reads leave results unchanged; writes to result registers are ignored.
`timescale 1ns/1ps
`default_nettype none
module rprr_top (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] corr_late_i,
  input  wire logic       corr_late_vld_i,
  input  wire logic [7:0] freq_sample_i,
  input  wire logic       freq_sample_vld_i,
  input  wire logic       header_det_i,
  input  wire logic       frame_end_i,
  input  wire logic       flight_start_i,
  input  wire logic       flight_stop_i,
  input  wire logic [7:0] rx_phase_i,
  input  wire logic [7:0] ref_phase_i,
  output logic      [3:0] clock_output_ctrl_o,
  output logic            phase_unit_enable_o,
  output logic            phase_if_path_invert_o,
  output logic            ranging_measure_enable_o
);
  logic [7:0]                    ctrl0_q;
  logic [7:0]                    corr_q;
  logic [7:0]                    freq_q;
  logic signed [rprr_pkg::ACC_W-1:0] facc_q;
  logic [15:0]                   fcnt_q;
  logic                          in_frame_q;
  logic [rprr_pkg::TIME_W-1:0]   tcnt_q;
  logic [rprr_pkg::TIME_W-1:0]   time_q;
  logic                          tcount_q;
  logic [8:0]                    pdiv_q;
  logic [7:0]                    phase_q;
  logic [7:0]                    phase_d;
  logic [7:0]                    rdata_d;
  logic                          tick16;
  logic                          range_en;
  logic                          phase_en;
  logic signed [rprr_pkg::ACC_W-1:0] favg;
  logic [7:0]                    fclip;

  assign range_en = ctrl0_q[rprr_pkg::BIT_RANGE_EN];
  assign phase_en = ctrl0_q[rprr_pkg::BIT_PHASE_EN];

  // Control register, bit 6 held at zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl0_q <= rprr_pkg::CTRL0_RESET;
    end else if (wr_i && addr_i == rprr_pkg::OFF_CTRL0) begin
      ctrl0_q <= wdata_i & rprr_pkg::CTRL0_WMASK; // [RULE_12]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clock_output_ctrl_o      <= rprr_pkg::CTRL0_RESET[3:0];
      phase_unit_enable_o      <= 1'b0;
      phase_if_path_invert_o   <= 1'b0;
      ranging_measure_enable_o <= 1'b0;
    end else begin
      clock_output_ctrl_o      <= ctrl0_q[3:0]; // [RULE_12]
      phase_unit_enable_o      <= phase_en;
      phase_if_path_invert_o   <= ctrl0_q[rprr_pkg::BIT_IF_INVERT];
      ranging_measure_enable_o <= range_en;
    end
  end

  // Late correlator tap capture
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      corr_q <= rprr_pkg::RESULT_RESET; // [RULE_01]
    end else if (range_en && corr_late_vld_i) begin
      corr_q <= corr_late_i; // [RULE_01]
    end
  end

  // Frame-wide mean of signed offset samples
  assign favg = (fcnt_q == 16'h0) ? facc_q :
                facc_q / $signed({16'h0, fcnt_q});
  // Saturate into signed 8-bit range
  assign fclip = (favg > 32'sd127) ? 8'h7f :
                 (favg < -32'sd128) ? 8'h80 : favg[7:0]; // [RULE_04]

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      freq_q     <= rprr_pkg::RESULT_RESET;
      facc_q     <= '0;
      fcnt_q     <= 16'h0;
      in_frame_q <= 1'b0;
    end else if (range_en) begin
      if (header_det_i) begin
        freq_q     <= freq_sample_i; // [RULE_02] [RULE_04]
        facc_q     <= rprr_pkg::ACC_W'($signed(freq_sample_i));
        fcnt_q     <= 16'h1;
        in_frame_q <= 1'b1;
      end else if (frame_end_i && in_frame_q) begin
        freq_q     <= fclip; // [RULE_03]
        in_frame_q <= 1'b0;
      end else if (in_frame_q && freq_sample_vld_i && fcnt_q != 16'hffff) begin
        facc_q <= facc_q + rprr_pkg::ACC_W'($signed(freq_sample_i));
        fcnt_q <= fcnt_q + 16'h1;
      end
    end
  end

  // 16 MHz count enable from the 40 MHz clock
  rprr_tick #(
    .NUM (rprr_pkg::TIMER_HZ),
    .DEN (rprr_pkg::CLK_HZ)
  ) u_tick16 (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (tcount_q),
    .tick_o    (tick16)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tcnt_q   <= '0;
      time_q   <= '0;
      tcount_q <= 1'b0;
    end else if (!range_en) begin
      tcount_q <= 1'b0;
    end else if (flight_start_i) begin
      tcnt_q   <= '0;
      tcount_q <= 1'b1;
    end else if (flight_stop_i && tcount_q) begin
      time_q   <= tcnt_q; // [RULE_05]
      tcount_q <= 1'b0;
    end else if (tcount_q && tick16) begin
      tcnt_q <= tcnt_q + 24'h1; // [RULE_06]
    end
  end

  // Phase delay relative to reference, sign flipped for inverse IF
  always_comb begin
    phase_d = rx_phase_i - ref_phase_i; // [RULE_08]
    if (ctrl0_q[rprr_pkg::BIT_IF_INVERT]) begin
      phase_d = 8'h0 - phase_d; // [RULE_11]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pdiv_q  <= rprr_pkg::PHASE_CNT_W;
      phase_q <= rprr_pkg::RESULT_RESET;
    end else if (!phase_en) begin
      pdiv_q <= rprr_pkg::PHASE_CNT_W; // [RULE_10]
    end else if (pdiv_q == 9'(rprr_pkg::PHASE_PERIOD_CYC - 1)) begin
      pdiv_q  <= rprr_pkg::PHASE_CNT_W;
      phase_q <= phase_d; // [RULE_09]
    end else begin
      pdiv_q <= pdiv_q + 9'h1;
    end
  end

  // Read decode; result registers are never written
  always_comb begin
    rdata_d = 8'h00;
    if (addr_i == rprr_pkg::OFF_CTRL0) begin
      rdata_d = ctrl0_q;
    end else if (addr_i == rprr_pkg::OFF_PHASE) begin
      rdata_d = phase_en ? phase_q : 8'h00; // [RULE_10]
    end else if (range_en && addr_i == rprr_pkg::OFF_CORR_P1K) begin
      rdata_d = corr_q; // [RULE_07] [RULE_13]
    end else if (range_en && addr_i == rprr_pkg::OFF_FREQ) begin
      rdata_d = freq_q; // [RULE_07]
    end else if (range_en && addr_i == rprr_pkg::OFF_TIME_LO) begin
      rdata_d = time_q[7:0]; // [RULE_05]
    end else if (range_en && addr_i == rprr_pkg::OFF_TIME_MID) begin
      rdata_d = time_q[15:8]; // [RULE_05]
    end else if (range_en && addr_i == rprr_pkg::OFF_TIME_HI) begin
      rdata_d = time_q[23:16]; // [RULE_05]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_d; // [RULE_13]
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** include/rprr_pkg.sv ***
// Constants for the ranging and phase result register bank
package rprr_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam logic [6:0] OFF_CTRL0    = 7'h03;
  localparam logic [6:0] OFF_PHASE    = 7'h3b;
  localparam logic [6:0] OFF_CORR_P1K = 7'h7b;
  localparam logic [6:0] OFF_FREQ     = 7'h7c;
  localparam logic [6:0] OFF_TIME_LO  = 7'h7d;
  localparam logic [6:0] OFF_TIME_MID = 7'h7e;
  localparam logic [6:0] OFF_TIME_HI  = 7'h7f;
  localparam logic [7:0] CTRL0_RESET  = 8'h09;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] CTRL0_WMASK  = 8'hbf;
  localparam int unsigned BIT_RANGE_EN  = 7;
  localparam int unsigned BIT_PHASE_EN  = 5;
  localparam int unsigned BIT_IF_INVERT = 4;
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned TIMER_HZ       = 16000000;
  localparam int unsigned PHASE_PERIOD_US = 8;
  localparam int unsigned PHASE_PERIOD_CYC =
    (CLK_HZ / 1000000) * PHASE_PERIOD_US;
  localparam int unsigned ACC_W = 32;
  localparam int unsigned TIME_W = 24;
  localparam logic [8:0] PHASE_CNT_W = 9'h000;
endpackage

// *** core/rprr_tick.sv ***
// Fractional rate enable generator (phase accumulator)
`timescale 1ns/1ps
`default_nettype none
module rprr_tick #(
  parameter int unsigned NUM = 1,
  parameter int unsigned DEN = 1
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic run_i,
  output logic      tick_o
);
  logic [31:0] acc_q;
  logic [32:0] sum;
  assign sum = {1'b0, acc_q} + 33'(NUM);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q  <= 32'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      acc_q  <= 32'h0;
      tick_o <= 1'b0;
    end else if (sum >= 33'(DEN)) begin
      acc_q  <= 32'(sum - 33'(DEN));
      tick_o <= 1'b1;
    end else begin
      acc_q  <= sum[31:0];
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** bench/rprr_asserts.sv ***
// Port checker for the ranging and phase register bank
`timescale 1ns/1ps
`default_nettype none
module rprr_asserts (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] clock_output_ctrl_o,
  input wire logic       phase_unit_enable_o,
  input wire logic       phase_if_path_invert_o,
  input wire logic       ranging_measure_enable_o
);
  wire logic [6:0] ctl = {ranging_measure_enable_o, phase_unit_enable_o,
                          phase_if_path_invert_o, clock_output_ctrl_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_cw;
    wr_i && addr_i == rprr_pkg::OFF_CTRL0;
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  chk_ctrl_reset: assert property (
    $fell(sys_rst_i) |->
      ctl == {rprr_pkg::CTRL0_RESET[7], rprr_pkg::CTRL0_RESET[5:0]})
    else $error("ctrl reset");
  // Control outputs follow the control register one cycle later
  chk_clk_fields: assert property (
    s_cw |-> ##2 clock_output_ctrl_o == $past(wdata_i[3:0], 2))
    else $error("clock fields");
  chk_enable_bits: assert property (
    s_cw |-> ##2
      ctl[6:4] == {$past(wdata_i[7], 2), $past(wdata_i[5:4], 2)})
    else $error("enable bits");
  chk_ctrl_hold: assert property (
    !(wr_i && addr_i == rprr_pkg::OFF_CTRL0) |-> ##2 $stable(ctl))
    else $error("ctrl hold");
  chk_ctrl_read: assert property (
    s_rd(rprr_pkg::OFF_CTRL0) |=>
      rdata_o == {ctl[6], 1'b0, ctl[5:0]})
    else $error("ctrl read");
  chk_range_gate: assert property (
    rd_i && addr_i >= rprr_pkg::OFF_CORR_P1K |=>
      ctl[6] || rdata_o == 8'h00)
    else $error("range gate");
  chk_phase_gate: assert property (
    s_rd(rprr_pkg::OFF_PHASE) |=> ctl[5] || rdata_o == 8'h00)
    else $error("phase gate");
  chk_read_idle: assert property (
    !rd_i |=> rdata_o == 8'h00) else $error("read idle");
endmodule
bind rprr_top rprr_asserts u_chk (.*);
`default_nettype wire

// *** bench/rprr_top_tb.sv ***
// Self-checking bench for the ranging and phase register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %0t %h %h", $time, g, e); end end
module rprr_top_tb;
  localparam logic [6:0] CT = rprr_pkg::OFF_CTRL0;
  localparam logic [6:0] PH = rprr_pkg::OFF_PHASE;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic  [6:0] addr_i = 7'h00;
  logic  [7:0] wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic  [7:0] corr_i = 8'h00;
  logic  [7:0] freq_i = 8'h00;
  logic  [7:0] rx_i = 8'h00;
  logic  [7:0] ref_i = 8'h00;
  logic  [5:0] pls = 6'h00;
  logic  [7:0] rdata_o, q, rx, rf;
  logic  [3:0] ck_o;
  logic  [2:0] en_o;
  logic [31:0] seed = 32'h84036ba8;
  logic [23:0] t;
  int          err_count = 0;
  int          samples_checked = 0;
  int          s;
  int          fs [2][4] = '{'{-20, 40, 10, 10}, '{-30, -50, -10, -30}};
  always #12.5 clk_i = ~clk_i;
  rprr_top dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .corr_late_i(corr_i), .corr_late_vld_i(pls[0]),
    .freq_sample_i(freq_i), .freq_sample_vld_i(pls[1]),
    .header_det_i(pls[2]), .frame_end_i(pls[3]),
    .flight_start_i(pls[4]), .flight_stop_i(pls[5]),
    .rx_phase_i(rx_i), .ref_phase_i(ref_i), .clock_output_ctrl_o(ck_o),
    .phase_unit_enable_o(en_o[1]), .phase_if_path_invert_o(en_o[0]),
    .ranging_measure_enable_o(en_o[2]));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic pulse(input int i);
    @(posedge clk_i);
    pls[i] <= 1'b1;
    @(posedge clk_i);
    pls <= 6'h00;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
    rd(a);
    `CHK(q, e)
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk_rd(CT, rprr_pkg::CTRL0_RESET);
    chk_rd(7'h10, 8'h00);
    wr(CT, 8'h80);
    for (int a = 8'h7b; a < 8'h80; a++) chk_rd(7'(a), 8'h00);
    chk_rd(PH, 8'h00);
    repeat (4) begin
      s = rnd();
      wr(CT, 8'(s));
      chk_rd(CT, 8'(s) & rprr_pkg::CTRL0_WMASK);
      `CHK({en_o, ck_o}, {s[7], s[5:0]})
    end
    wr(CT, 8'h80);
    corr_i <= rnd();
    pulse(0);
    wr(7'h7b, ~corr_i);
    chk_rd(7'h7b, corr_i);
    foreach (fs[f]) begin
      s = 0;
      for (int k = 0; k < 4; k++) begin
        freq_i <= 8'(fs[f][k]);
        s += fs[f][k];
        pulse(k == 0 ? 2 : 1);
        if (k == 0) chk_rd(7'h7c, 8'(fs[f][0]));
      end
      pulse(3);
      chk_rd(7'h7c, 8'(s / 4));
    end
    pulse(4);
    repeat (998) @(posedge clk_i);
    pulse(5);
    rd(7'h7d);
    t[7:0] = q;
    rd(7'h7e);
    t[15:8] = q;
    rd(7'h7f);
    t[23:16] = q;
    `CHK(t >= 24'd399 && t <= 24'd401, 1'b1)
    wr(CT, 8'h00);
    chk_rd(7'h7d, 8'h00);
    rx = rnd();
    rf = rnd();
    rx_i  <= rx;
    ref_i <= rf;
    wr(CT, 8'h20);
    repeat (200) @(posedge clk_i);
    chk_rd(PH, 8'h00);
    repeat (130) @(posedge clk_i);
    chk_rd(PH, rx - rf);
    wr(CT, 8'h30);
    repeat (330) @(posedge clk_i);
    chk_rd(PH, rf - rx);
    wr(CT, 8'h10);
    chk_rd(PH, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
